//--- hw/fpc_defs.vh
/*
 flash protection control: register offsets, field positions, reset
 values and state codes shared by the protection logic and its fuse store.
 assumes it is included by bare name from every design file.
*/
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH

// apb register map, byte addresses on a 12-bit address
`define FPC_AW 12
`define FPC_OFF_SECT_WP 12'h000
`define FPC_OFF_ACC_PROT 12'h004
`define FPC_OFF_PROT_DIS 12'h008
`define FPC_OFF_PROT_REEN 12'h00c
`define FPC_OFF_TEMP_UNPROT 12'h010
`define FPC_OFF_SET_PROT 12'h014
`define FPC_OFF_STATUS 12'h018
`define FPC_OFF_SECT_VOL 12'h01c

// fuse word indices inside the nonvolatile store
`define FPC_IDX_SECT_WP 2'h0
`define FPC_IDX_ACC_PROT 2'h1
`define FPC_IDX_PROT_DIS 2'h2
`define FPC_IDX_PROT_REEN 2'h3
`define FPC_NV_WORDS 4
`define FPC_NV_LAST 2'h3
`define FPC_NV_ERASED 16'hffff

// fields
`define FPC_NSECT 10
`define FPC_ACCESS_PROTECT_FUSE_BIT 0
`define FPC_DEBUG_PROTECT_FUSE_BIT 1
`define FPC_TEMPORARY_UNPROTECT_BIT_BIT 0
`define FPC_SP_IDX_HI 17
`define FPC_SP_IDX_LO 16
`define FPC_ST_WPF 0
`define FPC_ST_SPREJ 1
`define FPC_ST_PROT 2
`define FPC_ST_LOADED 3
`define FPC_ST_DEBUG 4
`define FPC_ST_TEMPORARY_UNPROTECT_BIT 5

// software trap raised by a refused data read
`define FPC_TRAP_NUM 16'h009b

// load sequencer states
`define FPC_S_RD 2'h0
`define FPC_S_CAP 2'h1
`define FPC_S_RUN 2'h2

`endif

//--- hw/fpc_nv_cells.v
/*
 fpc_nv_cells: the four one-time-programmable protection words.
 assumes por is a same-clock pulse standing for a factory-erased array;
 rst does not touch the cells, since they are nonvolatile.
*/
`timescale 1ns/100ps
`include "fpc_defs.vh"

module fpc_nv_cells (
   input wire clock,
   input wire por,
   input wire prog_en,
   input wire [1:0] prog_idx,
   input wire [15:0] prog_data,
   input wire [1:0] rd_idx,
   output reg [15:0] rd_data_q
);
   reg [15:0] cell_q [0:`FPC_NV_WORDS-1];
   integer i;

   always @(posedge clock) begin
      if (por) begin
         for (i = 0; i < `FPC_NV_WORDS; i = i + 1) begin
            cell_q[i] <= `FPC_NV_ERASED;
         end
      end else if (prog_en) begin
         // cells only go from erased 1 to programmed 0
         cell_q[prog_idx] <= cell_q[prog_idx] & prog_data; // R1
      end
      rd_data_q <= cell_q[rd_idx];
   end
endmodule // fpc_nv_cells

//--- hw/fpc_top.v
/*
 fpc_top: protection logic for the on-chip program flash. holds the
 volatile copies of the protection fuses, judges cpu and pec data
 accesses, sector program/erase requests and apb register writes.
 assumes the cpu side drives its request strobes on this clock, and that
 cpu_fetch_flash tells whether the instruction now acting came from flash.
*/
// The implementer's own choices: the APB register port and the placing of the registers.
// Behaviour
// R1 - four one-time-programmable protection words, bits only go 1 to 0
// R2 - ten sector write-protect bits; 0 blocks program or erase of sector
// R3 - access fuse 0 refuses data access unless instruction came from flash
// R4 - debug fuse 1 enables debug features; 0 disables debug and test modes
// R5 - disable fuse x at 0 with enable fuse x at 1 cancels access fuse
// R6 - disable fuse 0 programmable only after debug and access fuses are 0
// R7 - disable fuse x above 0 needs enable fuse x-1 already at 0
// R8 - enable fuse x at 0 with disable fuse x+1 at 1 restores access fuse
// R9 - enable fuse x programmable only after disable fuse x is 0
// R10 - temporary-unprotect bit suspends protection; set only from flash code
// R11 - protected exactly when access fuse and temporary-unprotect are both 0
// R12 - software enables protection from ram: unprotect, set fuse, clear bit
// R13 - at most 16 disable/enable cycles; needs temporary unprotection first
// R14 - protected: ram/external writes dropped, reads give dummy and trap
// R15 - protected: peripheral event controller flash transfers blocked too
// R16 - protected: all control register writes blocked; reads still allowed (code still accepts temporary-unprotect writes)
// R17 - set-protection writing 1 into sector bits lifts their protection
// R18 - reset or set-protection writing 0 restores sector protection
// R19 - sector unprotection changes the volatile copy only, not the fuses
// R20 - reset or writing 0 to temporary-unprotect bit restores protection
// R21 - reset forces protections on, then loads fuses into volatile copies
// R22 - program/erase of protected sector sets flag; others still proceed
// R23 - until fuse load completes, deny protected accesses and reg writes
`timescale 1ns/100ps
`include "fpc_defs.vh"

module fpc_top (
   input wire clock,
   input wire rst,
   input wire por,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`FPC_AW-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire cpu_fetch_flash,
   input wire da_req,
   input wire da_write,
   input wire da_pec,
   input wire da_fetch_flash,
   output reg da_done,
   output reg da_allow,
   output reg da_trap,
   output reg [15:0] trap_number,
   input wire pe_req,
   input wire [`FPC_NSECT-1:0] pe_sectors,
   output reg pe_done,
   output reg [`FPC_NSECT-1:0] pe_sector_go,
   output reg debug_enable,
   output reg access_protected
);
   // volatile copies that govern operation
   reg [`FPC_NSECT-1:0] sect_vol_q;
   reg [15:0] acc_vol_q;
   reg [15:0] dis_vol_q;
   reg [15:0] reen_vol_q;
   reg temporary_unprotect_bit_q;
   reg loaded_q;
   reg wpf_q;
   reg sprej_q;
   reg [1:0] state_q;
   reg [1:0] cnt_q;
   reg [1:0] state_d;
   reg [1:0] cnt_d;

   // nonvolatile store handshake
   wire [15:0] nv_rd;
   reg [1:0] nv_rd_idx;
   reg nv_prog;
   reg [1:0] nv_prog_idx;
   reg [15:0] nv_prog_data;

   // protection state
   wire access_protect_fuse_fuse;
   wire debug_protect_fuse_fuse;
   wire acc_cancel;
   wire prot;

   // apb decode
   wire apb_acc;
   wire apb_done;
   wire wr_done;
   reg mapped;
   reg [31:0] rd_mux;

   // set-protection judgement
   wire [1:0] sp_idx;
   wire [15:0] sp_data;
   wire [15:0] dis_new0;
   wire [15:0] reen_new0;
   reg sp_bad;
   wire sp_hit;
   wire sp_ok;
   wire sp_rej;

   // access judgement
   wire da_pass;
   wire [`FPC_NSECT-1:0] pe_blocked;

   fpc_nv_cells u_nv (
      .clock(clock),
      .por(por),
      .prog_en(nv_prog),
      .prog_idx(nv_prog_idx),
      .prog_data(nv_prog_data),
      .rd_idx(nv_rd_idx),
      .rd_data_q(nv_rd)
   );

   assign access_protect_fuse_fuse = acc_vol_q[`FPC_ACCESS_PROTECT_FUSE_BIT];
   assign debug_protect_fuse_fuse = acc_vol_q[`FPC_DEBUG_PROTECT_FUSE_BIT];
   // any pair with disable programmed and enable still erased cancels;
   // the pair chain means the newest pair decides, so a programmed enable
   // with the next disable still erased leaves no cancelling pair
   assign acc_cancel = |(~dis_vol_q & reen_vol_q); // R5 R8
   assign prot = !loaded_q
                 || (!access_protect_fuse_fuse && !acc_cancel && !temporary_unprotect_bit_q); // R11 R23

   // fuse load after reset: issue a read, capture it next cycle
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         `FPC_S_RD: begin
            state_d = `FPC_S_CAP;
         end
         `FPC_S_CAP: begin
            if (cnt_q == `FPC_NV_LAST) begin
               state_d = `FPC_S_RUN;
            end else begin
               state_d = `FPC_S_RD;
               cnt_d = cnt_q + 2'h1;
            end
         end
         `FPC_S_RUN: begin
            state_d = `FPC_S_RUN;
         end
         default: begin
            state_d = `FPC_S_RD;
            cnt_d = 2'h0;
         end
      endcase
   end

   // steer to the bus address one edge before run: a read whose access
   // phase meets the end of the load must not see the last fuse word
   always @* begin
      if (state_d == `FPC_S_RUN) begin
         nv_rd_idx = paddr[3:2];
      end else begin
         nv_rd_idx = cnt_q; // R21
      end
   end

   assign apb_acc = psel && penable;
   // one wait cycle gives the fuse store time to answer a read
   assign apb_done = apb_acc && pready;
   assign wr_done = apb_done && pwrite && mapped;

   always @* begin
      case (paddr)
         `FPC_OFF_SECT_WP: mapped = 1'b1;
         `FPC_OFF_ACC_PROT: mapped = 1'b1;
         `FPC_OFF_PROT_DIS: mapped = 1'b1;
         `FPC_OFF_PROT_REEN: mapped = 1'b1;
         `FPC_OFF_TEMP_UNPROT: mapped = 1'b1;
         `FPC_OFF_SET_PROT: mapped = 1'b1;
         `FPC_OFF_STATUS: mapped = 1'b1;
         `FPC_OFF_SECT_VOL: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always @* begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         // fuse words read back the cells, so a temporary sector
         // unprotection cannot be seen here
         `FPC_OFF_SECT_WP: rd_mux[15:0] = nv_rd; // R19
         `FPC_OFF_ACC_PROT: rd_mux[15:0] = nv_rd;
         `FPC_OFF_PROT_DIS: rd_mux[15:0] = nv_rd;
         `FPC_OFF_PROT_REEN: rd_mux[15:0] = nv_rd;
         `FPC_OFF_TEMP_UNPROT: rd_mux[`FPC_TEMPORARY_UNPROTECT_BIT_BIT] = temporary_unprotect_bit_q;
         `FPC_OFF_STATUS: begin
            rd_mux[`FPC_ST_WPF] = wpf_q;
            rd_mux[`FPC_ST_SPREJ] = sprej_q;
            rd_mux[`FPC_ST_PROT] = prot;
            rd_mux[`FPC_ST_LOADED] = loaded_q;
            rd_mux[`FPC_ST_DEBUG] = loaded_q && debug_protect_fuse_fuse;
            rd_mux[`FPC_ST_TEMPORARY_UNPROTECT_BIT] = temporary_unprotect_bit_q;
         end
         `FPC_OFF_SECT_VOL: rd_mux[`FPC_NSECT-1:0] = sect_vol_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // set-protection command: index in the upper field, word in the lower
   assign sp_idx = pwdata[`FPC_SP_IDX_HI:`FPC_SP_IDX_LO];
   assign sp_data = pwdata[15:0];
   assign dis_new0 = dis_vol_q & ~sp_data;
   assign reen_new0 = reen_vol_q & ~sp_data;

   always @* begin
      sp_bad = 1'b0;
      if (sp_idx == `FPC_IDX_PROT_DIS) begin
         if (dis_new0[0] && (access_protect_fuse_fuse || debug_protect_fuse_fuse)) begin
            sp_bad = 1'b1; // R6
         end
         if (|(dis_new0[15:1] & reen_vol_q[14:0])) begin
            sp_bad = 1'b1; // R7
         end
      end else if (sp_idx == `FPC_IDX_PROT_REEN) begin
         if (|(reen_new0 & dis_vol_q)) begin
            sp_bad = 1'b1; // R9
         end
      end
   end

   assign sp_hit = wr_done && (paddr == `FPC_OFF_SET_PROT);
   // set protection never runs from flash, and not while protected;
   // the pair sequence therefore needs temporary unprotection first
   assign sp_ok = sp_hit && !prot && !cpu_fetch_flash && !sp_bad; // R13 R16
   assign sp_rej = sp_hit && !sp_ok;

   always @* begin
      nv_prog = sp_ok;
      nv_prog_idx = sp_idx;
      nv_prog_data = sp_data; // R1
   end

   // access judgement: pec never counts as a fetch from flash
   assign da_pass = !prot || (da_fetch_flash && !da_pec); // R3 R15
   assign pe_blocked = pe_sectors & ~sect_vol_q; // R2

   always @(posedge clock) begin
      if (rst) begin
         state_q <= `FPC_S_RD;
         cnt_q <= 2'h0;
         loaded_q <= 1'b0;
         // everything protected until the cells are read
         sect_vol_q <= {`FPC_NSECT{1'b0}}; // R21
         acc_vol_q <= 16'h0000;
         dis_vol_q <= `FPC_NV_ERASED;
         reen_vol_q <= `FPC_NV_ERASED;
         temporary_unprotect_bit_q <= 1'b0; // R20
         wpf_q <= 1'b0;
         sprej_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         if (state_q == `FPC_S_CAP) begin
            case (cnt_q)
               `FPC_IDX_SECT_WP: sect_vol_q <= nv_rd[`FPC_NSECT-1:0]; // R21
               `FPC_IDX_ACC_PROT: acc_vol_q <= nv_rd;
               `FPC_IDX_PROT_DIS: dis_vol_q <= nv_rd;
               default: reen_vol_q <= nv_rd;
            endcase
            if (cnt_q == `FPC_NV_LAST) begin
               loaded_q <= 1'b1;
            end
         end
         if (sp_ok) begin
            case (sp_idx)
               // sector copy takes the word: 1 lifts, 0 restores; the fuse copies only clear bits
               `FPC_IDX_SECT_WP: begin
                  sect_vol_q <= sp_data[`FPC_NSECT-1:0]; // R17 R18 R19
               end
               `FPC_IDX_ACC_PROT: acc_vol_q <= acc_vol_q & sp_data;
               `FPC_IDX_PROT_DIS: dis_vol_q <= dis_vol_q & sp_data;
               default: reen_vol_q <= reen_vol_q & sp_data;
            endcase
         end
         // setting needs flash code; clearing is allowed from anywhere
         if (wr_done && paddr == `FPC_OFF_TEMP_UNPROT) begin
            if (!pwdata[`FPC_TEMPORARY_UNPROTECT_BIT_BIT]) begin
               temporary_unprotect_bit_q <= 1'b0; // R20
            end else if (cpu_fetch_flash && loaded_q) begin
               temporary_unprotect_bit_q <= 1'b1; // R10
            end
         end
         // set wins over a same-cycle write-one clear
         if (pe_req && state_q == `FPC_S_RUN && |pe_blocked) begin
            wpf_q <= 1'b1; // R22
         end else if (wr_done && !prot && paddr == `FPC_OFF_STATUS
                      && pwdata[`FPC_ST_WPF]) begin
            wpf_q <= 1'b0; // R16
         end
         if (sp_rej) begin
            sprej_q <= 1'b1;
         end else if (wr_done && !prot && paddr == `FPC_OFF_STATUS
                      && pwdata[`FPC_ST_SPREJ]) begin
            sprej_q <= 1'b0;
         end
      end
   end

   // apb slave: ready one cycle into the access phase, held off during load
   always @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (apb_acc && !pready && state_q == `FPC_S_RUN) begin
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

   // data access and program/erase answers, one cycle after the request
   always @(posedge clock) begin
      if (rst) begin
         da_done <= 1'b0;
         da_allow <= 1'b0;
         da_trap <= 1'b0;
         trap_number <= 16'h0000;
         pe_done <= 1'b0;
         pe_sector_go <= {`FPC_NSECT{1'b0}};
         debug_enable <= 1'b0;
         access_protected <= 1'b1;
      end else begin
         da_done <= da_req;
         da_allow <= da_req && da_pass; // R3 R14 R15
         // a refused cpu read gets dummy data and the trap; writes vanish
         da_trap <= da_req && !da_pass && !da_write && !da_pec; // R14
         if (da_req && !da_pass && !da_write && !da_pec) begin
            trap_number <= `FPC_TRAP_NUM; // R14
         end
         pe_done <= pe_req;
         if (pe_req) begin
            // protected sectors are skipped, the rest proceed
            pe_sector_go <= loaded_q ? (pe_sectors & sect_vol_q)
                            : {`FPC_NSECT{1'b0}}; // R2 R22 R23
         end else begin
            pe_sector_go <= {`FPC_NSECT{1'b0}};
         end
         debug_enable <= loaded_q && debug_protect_fuse_fuse; // R4
         access_protected <= prot; // R11
      end
   end
endmodule // fpc_top

//--- test/fpc_props.sv
/*
 fpc_props: port-level checks of the flash protection logic.
 assumes it is bound into fpc_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`include "fpc_defs.vh"

module fpc_props (
   input wire clock,
   input wire rst,
   input wire pready,
   input wire pslverr,
   input wire [31:0] prdata,
   input wire da_req,
   input wire da_write,
   input wire da_pec,
   input wire da_fetch_flash,
   input wire da_done,
   input wire da_allow,
   input wire da_trap,
   input wire [15:0] trap_number,
   input wire pe_req,
   input wire [`FPC_NSECT-1:0] pe_sectors,
   input wire pe_done,
   input wire [`FPC_NSECT-1:0] pe_sector_go,
   input wire debug_enable,
   input wire access_protected
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   property p_da_done;
      da_req |=> da_done;
   endproperty
   a_da_done: assert property (p_da_done) else $error("no da_done");
   property p_fetch;
      da_req && !da_pec && da_fetch_flash |=> da_allow;
   endproperty
   a_fetch: assert property (p_fetch) else $error("flash code denied");
   property p_trap;
      da_trap |-> !da_allow && $past(da_write) == 0 && $past(da_pec) == 0;
   endproperty
   a_trap: assert property (p_trap) else $error("bad trap");
   property p_trap_num;
      da_trap |-> trap_number == 16'h009b;
   endproperty
   a_trap_num: assert property (p_trap_num) else $error("trap number");
   property p_pe;
      pe_req |=> pe_done;
   endproperty
   a_pe: assert property (p_pe) else $error("no pe_done");
   property p_pe_go;
      pe_sector_go != 0 |->
         pe_done && (pe_sector_go & ~$past(pe_sectors)) == 0;
   endproperty
   a_pe_go: assert property (p_pe_go) else $error("untargeted sector");
   property p_reset;
      $past(rst) |-> access_protected && !debug_enable && !pready;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state");
   property p_load;
      $fell(rst) |-> access_protected [*8];
   endproperty
   a_load: assert property (p_load) else $error("early unprotect");
   property p_wait;
      $fell(rst) |-> !pready [*8];
   endproperty
   a_wait: assert property (p_wait) else $error("apb before load");
   property p_read;
      pslverr || prdata != 0 |-> pready;
   endproperty
   a_read: assert property (p_read) else $error("stray read data");
   c_trap: cover property (da_trap);
   c_block: cover property (pe_done && pe_sector_go != $past(pe_sectors));
   c_prot: cover property ($fell(access_protected));
endmodule // fpc_props

bind fpc_top fpc_props i_fpc_props (.clock(clock), .rst(rst),
   .pready(pready), .pslverr(pslverr), .prdata(prdata), .da_req(da_req),
   .da_write(da_write), .da_pec(da_pec), .da_fetch_flash(da_fetch_flash),
   .da_done(da_done), .da_allow(da_allow), .da_trap(da_trap),
   .trap_number(trap_number), .pe_req(pe_req), .pe_sectors(pe_sectors),
   .pe_done(pe_done), .pe_sector_go(pe_sector_go),
   .debug_enable(debug_enable), .access_protected(access_protected));

//--- test/fpc_cpu_model.sv
/*
 fpc_cpu_model: cpu core and pec issuing flash data and program/erase
 requests. assumes each request is answered on the design's done strobe.
*/
`timescale 1ns/100ps

module fpc_cpu_model (
   input wire clock,
   input wire da_done,
   input wire da_allow,
   input wire da_trap,
   input wire pe_done,
   input wire [9:0] pe_sector_go,
   output logic da_req,
   output logic da_write,
   output logic da_pec,
   output logic da_fetch_flash,
   output logic pe_req,
   output logic [9:0] pe_sectors
);
   initial {da_req, da_write, da_pec, da_fetch_flash, pe_req} = 5'h00;
   initial pe_sectors = 10'h000;
   // released qualifiers flip so a stale value is never mistaken for live
   task automatic access(input logic w, p, f, output logic al, tr);
      @(posedge clock);
      da_req <= 1;
      {da_write, da_pec, da_fetch_flash} <= {w, p, f};
      @(posedge clock);
      da_req <= 0;
      {da_write, da_pec, da_fetch_flash} <= ~{w, p, f};
      // no cycle count assumed; the bench watchdog ends a hung wait
      while (da_done !== 1) begin
         @(posedge clock);
      end
      al = da_allow;
      tr = da_trap;
   endtask
   task automatic prog(input logic [9:0] s, output logic [9:0] g);
      @(posedge clock);
      pe_req <= 1;
      pe_sectors <= s;
      @(posedge clock);
      pe_req <= 0;
      pe_sectors <= ~s;
      while (pe_done !== 1) begin
         @(posedge clock);
      end
      g = pe_sector_go;
   endtask
endmodule // fpc_cpu_model

//--- test/testbench.sv
/*
 testbench: apb register tasks and cpu model calls checking protection.
 assumes fpc_top, fpc_cpu_model and the bound checker are compiled.
*/
`timescale 1ns/100ps
`include "fpc_defs.vh"

module testbench;
   logic clock = 0, rst = 1, por = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, v;
   logic pready, pslverr, e, cpu_fetch_flash = 0;
   logic da_req, da_write, da_pec, da_fetch_flash, da_done, da_allow;
   logic da_trap, pe_req, pe_done, debug_enable, access_protected;
   logic [15:0] trap_number;
   logic [9:0] pe_sectors, pe_sector_go;
   int n_fail = 0, check_count = 0;
   always #25 clock = ~clock;
   fpc_top i_fpc_top (.clock(clock), .rst(rst), .por(por), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_fetch_flash(cpu_fetch_flash), .da_req(da_req),
      .da_write(da_write), .da_pec(da_pec), .da_fetch_flash(da_fetch_flash),
      .da_done(da_done), .da_allow(da_allow), .da_trap(da_trap),
      .trap_number(trap_number), .pe_req(pe_req), .pe_sectors(pe_sectors),
      .pe_done(pe_done), .pe_sector_go(pe_sector_go),
      .debug_enable(debug_enable), .access_protected(access_protected));
   fpc_cpu_model i_fpc_cpu_model (.clock(clock), .da_done(da_done),
      .da_allow(da_allow), .da_trap(da_trap), .pe_done(pe_done),
      .pe_sector_go(pe_sector_go), .da_req(da_req), .da_write(da_write),
      .da_pec(da_pec), .da_fetch_flash(da_fetch_flash), .pe_req(pe_req),
      .pe_sectors(pe_sectors));
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, got);
      check_count++;
      if (got !== ex) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      // no cycle count assumed; the watchdog ends a hung wait
      do begin
         @(posedge clock);
      end while (pready !== 1);
      v = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      apb(0, a, 32'h0);
      chk("register", ex, v);
   endtask
   task automatic sb(input int b, input logic ex);
      apb(0, `FPC_OFF_STATUS, 32'h0);
      chk("status bit", ex, v[b]);
   endtask
   task automatic sp(input logic [1:0] i, input logic [15:0] w);
      apb(1, `FPC_OFF_SET_PROT, {14'h0, i, w});
   endtask
   task automatic fl(input logic f);
      @(posedge clock);
      cpu_fetch_flash <= f;
   endtask
   task automatic tu(input logic f, input logic d);
      fl(f);
      apb(1, `FPC_OFF_TEMP_UNPROT, {31'h0, d});
      fl(0);
   endtask
   task automatic da(input logic w, p, f, input logic ea, et);
      logic al, tr;
      i_fpc_cpu_model.access(w, p, f, al, tr);
      chk("da_allow", ea, al);
      chk("da_trap", et, tr);
   endtask
   task automatic pe(input logic [9:0] s, ex);
      logic [9:0] g;
      i_fpc_cpu_model.prog(s, g);
      chk("pe_sector_go", ex, g);
   endtask
   task automatic ap(input logic ex);
      repeat (2) @(posedge clock);
      chk("access_protected", ex, access_protected);
   endtask
   task automatic reboot;
      @(posedge clock);
      rst <= 1;
      repeat (12) @(posedge clock);
      rst <= 0;
   endtask
   initial @(posedge clock) por <= 0;
   initial begin
      #500000;
      n_fail++;
      final_report;
   end
   initial begin
      reboot;
      da(0, 0, 0, 0, 1);
      pe(10'h3ff, 10'h000);
      for (int i = 0; i < 4; i++)
         rd(i * 4, 32'hffff);
      apb(0, 12'h020, 32'h0);
      chk("pslverr", 1, e);
      sb(`FPC_ST_LOADED, 1);
      chk("debug_enable", 1, debug_enable);
      ap(0);
      sp(0, 16'hfffc);
      rd(`FPC_OFF_SECT_WP, 32'hfffc);
      rd(`FPC_OFF_SECT_VOL, 32'h3fc);
      pe(10'h3ff, 10'h3fc);
      sb(`FPC_ST_WPF, 1);
      apb(1, `FPC_OFF_STATUS, 32'h3);
      sb(`FPC_ST_WPF, 0);
      sp(0, 16'hffff);
      rd(`FPC_OFF_SECT_WP, 32'hfffc);
      pe(10'h3ff, 10'h3ff);
      sp(0, 16'hfffe);
      pe(10'h3ff, 10'h3fe);
      // set-protection from flash code must be refused
      fl(1);
      sp(0, 16'hffff);
      fl(0);
      sb(`FPC_ST_SPREJ, 1);
      pe(10'h3ff, 10'h3fe);
      reboot;
      rd(`FPC_OFF_SECT_WP, 32'hfffc);
      pe(10'h3ff, 10'h3fc);
      sp(2, 16'hfffe);
      rd(`FPC_OFF_PROT_DIS, 32'hffff);
      sp(3, 16'hfffe);
      rd(`FPC_OFF_PROT_REEN, 32'hffff);
      tu(0, 1);
      sb(`FPC_ST_TEMPORARY_UNPROTECT_BIT, 0);
      tu(1, 1);
      sb(`FPC_ST_TEMPORARY_UNPROTECT_BIT, 1);
      sp(1, 16'hfffc);
      rd(`FPC_OFF_ACC_PROT, 32'hfffc);
      ap(0);
      tu(0, 0);
      ap(1);
      sb(`FPC_ST_PROT, 1);
      chk("trap_number", 0, trap_number);
      da(0, 0, 0, 0, 1);
      chk("trap_number", 16'h009b, trap_number);
      da(1, 0, 0, 0, 0);
      da(0, 0, 1, 1, 0);
      da(0, 1, 1, 0, 0);
      sp(0, 16'h0000);
      rd(`FPC_OFF_SECT_WP, 32'hfffc);
      reboot;
      rd(`FPC_OFF_ACC_PROT, 32'hfffc);
      ap(1);
      chk("debug_enable", 0, debug_enable);
      sb(`FPC_ST_DEBUG, 0);
      tu(1, 1);
      da(0, 1, 0, 1, 0);
      sp(2, 16'hfffe);
      rd(`FPC_OFF_PROT_DIS, 32'hfffe);
      tu(0, 0);
      ap(0);
      sp(2, 16'hfffc);
      rd(`FPC_OFF_PROT_DIS, 32'hfffe);
      sp(3, 16'hfffe);
      rd(`FPC_OFF_PROT_REEN, 32'hfffe);
      ap(1);
      tu(1, 1);
      sp(2, 16'hfffc);
      rd(`FPC_OFF_PROT_DIS, 32'hfffc);
      tu(0, 0);
      ap(0);
      final_report;
   end
endmodule // testbench
